// File: core/sbm_params.svh
// constants of the serial bus master command sequencer
`ifndef SBM_PARAMS_SVH
`define SBM_PARAMS_SVH

// timing
`define SBM_CLK_NS        8
`define SBM_TICK_NS       1000
`define SBM_TICK_CYCLES   (`SBM_TICK_NS / `SBM_CLK_NS)
`define SBM_VPP_512_US    512
`define SBM_SPU_524_MS    524
`define SBM_DUR_REF_CODE  4
`define SBM_VPP_UNIT_US   (`SBM_VPP_512_US >> `SBM_DUR_REF_CODE)
`define SBM_SPU_UNIT_US   ((`SBM_SPU_524_MS * 1000) >> `SBM_DUR_REF_CODE)
`define SBM_DUR_INFINITE  3'h7

// command codes
`define SBM_CODE_DATA     8'he1
`define SBM_CODE_CMD      8'he3
`define SBM_CODE_TERM     8'hf1
`define SBM_CODE_READ     8'hff

// field positions
`define SBM_CFG_PARAM     6:4
`define SBM_CFG_VALUE     3:1
`define SBM_PULSE_VPP     4
`define SBM_PULSE_ARM     1
`define SBM_RST_PREFIX    6'h33

// configuration parameter selectors
`define SBM_PARAM_VPP     3'h2
`define SBM_PARAM_SPU     3'h3
`define SBM_PARAM_BAUD    3'h7

// reset values
`define SBM_VPP_DUR_RST   3'h4
`define SBM_SPU_DUR_RST   3'h4
`define SBM_BAUD_RST      3'h0

`endif

// File: core/sbm_pkg.sv
// types of the serial bus master command sequencer
package sbm_pkg;

  typedef enum logic [3:0]
  {
    SBM_ST_IDLE  = 4'b0001,
    SBM_ST_BUS   = 4'b0010,
    SBM_ST_RST   = 4'b0100,
    SBM_ST_PULSE = 4'b1000
  } sbm_state_t;

  typedef struct packed
  {
    logic       rd;
    logic [7:0] data;
  } sbm_byte_req_t;

endpackage

// File: core/sbm_pulse_timer.sv
// microsecond pulse timer for strong pullup and programming pulses
`timescale 1ns/100ps
`include "sbm_params.svh"

module sbm_pulse_timer #(
  parameter int unsigned TICK_CYCLES = `SBM_TICK_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [21:0] len_us_i,
  input  wire logic        infinite_i,
  input  wire logic        stop_i,
  output logic             active_o,
  output logic             done_o
);

  logic [6:0]  div_q;
  logic [21:0] cnt_q;
  logic        inf_q;
  logic        tick;

  // =====================================
  // one microsecond enable
  assign tick = (div_q == 7'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_q <= 7'h00;
    else if (start_i || tick)
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end

  // =====================================
  // duration count
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      active_o <= 1'b0;
      done_o   <= 1'b0;
      cnt_q    <= 22'h000000;
      inf_q    <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        active_o <= 1'b1;
        cnt_q    <= len_us_i;
        inf_q    <= infinite_i;
      end
      else if (active_o && (stop_i || (!inf_q && tick && cnt_q <= 22'h000001)))
      begin
        active_o <= 1'b0;
        done_o   <= 1'b1;
      end
      else if (active_o && tick && !inf_q)
        cnt_q <= cnt_q - 22'h000001;
    end
  end

endmodule

// File: core/sbm_cmd_seq.sv
// command and data mode interpreter of a serial single-wire bus master
// =====================================
// Summary of operation
// - code 29 stores 512us program pulse, answers 28
// - code 39 stores 524ms pullup, answers 38
// - ff in data mode reads bus byte back
// - armed data byte: data reply, later pulse reply
// - baud values 100 to 111 invert serial lines
// - termination in command mode ends pulse silently, then pulse reply
// - armed data mode: pullup after every byte
// - one host byte buffered during execution
`timescale 1ns/100ps
`include "sbm_params.svh"

module sbm_cmd_seq #(
  parameter int unsigned TICK_CYCLES = `SBM_TICK_CYCLES
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_data_i,
  output logic                       rx_ready_o,
  output logic                       tx_valid_o,
  output logic [7:0]                 tx_data_o,
  input  wire logic                  tx_ready_i,
  output sbm_pkg::sbm_byte_req_t     bus_req_o,
  output logic                       bus_req_valid_o,
  input  wire logic                  bus_done_i,
  input  wire logic [7:0]            bus_rd_data_i,
  output logic                       bus_rst_req_o,
  input  wire logic                  bus_rst_done_i,
  input  wire logic [1:0]            presence_i,
  output logic                       strong_pullup_o,
  output logic                       prog_pulse_o,
  output logic                       serial_invert_o,
  output logic [1:0]                 baud_sel_o,
  output logic                       data_mode_o
);

  sbm_pkg::sbm_state_t state_q;
  logic [7:0]  buf_q;
  logic        buf_v_q;
  logic        consume;
  logic        esc_q;
  logic        armed_q;
  logic        pulse_vpp_q;
  logic        pulse_end_q;
  logic [7:0]  pulse_code_q;
  logic [2:0]  vpp_dur_q;
  logic [2:0]  spu_dur_q;
  logic [2:0]  baud_q;
  logic        t_start;
  logic        t_vpp;
  logic [2:0]  t_code;
  logic [21:0] t_len;
  logic        t_stop;
  logic        t_active;
  logic        t_done;
  logic        can_take;
  logic        is_pulse;
  logic        is_rst;
  logic        is_cfg;

  // =====================================
  // one byte host buffer
  // host pacing is trusted; a byte sent while full is simply not taken
  assign rx_ready_o = !buf_v_q;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      buf_v_q <= 1'b0;
      buf_q   <= 8'h00;
    end
    else if (rx_valid_i && !buf_v_q)
    begin
      buf_v_q <= 1'b1;
      buf_q   <= rx_data_i;
    end
    else if (consume)
      buf_v_q <= 1'b0;
  end

  // =====================================
  // decode
  assign can_take = buf_v_q && (state_q == sbm_pkg::SBM_ST_IDLE) && !tx_valid_o;
  assign is_pulse = (buf_q[7:5] == 3'h7) && (buf_q[3:2] == 2'h3) && buf_q[0];
  assign is_rst   = (buf_q[7:4] == 4'hc) && (buf_q[1:0] == 2'h1);
  assign is_cfg   = buf_q[0] && !buf_q[7];
  assign t_stop   = (state_q == sbm_pkg::SBM_ST_PULSE) && buf_v_q && !data_mode_o
                    && (buf_q == `SBM_CODE_TERM);

  always_comb
  begin
    consume = 1'b0;
    if (t_stop)
      consume = 1'b1;
    else if (can_take)
      consume = !(data_mode_o && esc_q && buf_q != `SBM_CODE_CMD);
  end

  // =====================================
  // pulse timer
  always_comb
  begin
    t_start = 1'b0;
    t_vpp   = 1'b0;
    if (state_q == sbm_pkg::SBM_ST_BUS && bus_done_i && armed_q)
      t_start = 1'b1;
    else if (can_take && !data_mode_o && is_pulse)
    begin
      t_start = 1'b1;
      t_vpp   = buf_q[`SBM_PULSE_VPP];
    end
  end

  assign t_code = t_vpp ? vpp_dur_q : spu_dur_q;
  assign t_len  = t_vpp ? (22'(`SBM_VPP_UNIT_US) << t_code)
                        : (22'(`SBM_SPU_UNIT_US) << t_code);

  sbm_pulse_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .start_i    (t_start),
    .len_us_i   (t_len),
    .infinite_i (t_code == `SBM_DUR_INFINITE),
    .stop_i     (t_stop),
    .active_o   (t_active),
    .done_o     (t_done)
  );

  assign strong_pullup_o = t_active && !pulse_vpp_q;
  assign prog_pulse_o    = t_active && pulse_vpp_q;
  assign serial_invert_o = baud_q[2];
  assign baud_sel_o      = baud_q[1:0];

  // =====================================
  // configuration store
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vpp_dur_q <= `SBM_VPP_DUR_RST;
      spu_dur_q <= `SBM_SPU_DUR_RST;
      baud_q    <= `SBM_BAUD_RST;
    end
    else if (can_take && !data_mode_o && is_cfg)
    begin
      case (buf_q[`SBM_CFG_PARAM])
        `SBM_PARAM_VPP:  vpp_dur_q <= buf_q[`SBM_CFG_VALUE];
        `SBM_PARAM_SPU:  spu_dur_q <= buf_q[`SBM_CFG_VALUE];
        `SBM_PARAM_BAUD: baud_q    <= buf_q[`SBM_CFG_VALUE];
        default:         baud_q    <= baud_q;
      endcase
    end
  end

  // =====================================
  // sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q         <= sbm_pkg::SBM_ST_IDLE;
      data_mode_o     <= 1'b0;
      esc_q           <= 1'b0;
      armed_q         <= 1'b0;
      pulse_vpp_q     <= 1'b0;
      pulse_end_q     <= 1'b0;
      pulse_code_q    <= 8'h00;
      bus_req_o       <= '0;
      bus_req_valid_o <= 1'b0;
      bus_rst_req_o   <= 1'b0;
      tx_valid_o      <= 1'b0;
      tx_data_o       <= 8'h00;
    end
    else
    begin
      if (tx_valid_o && tx_ready_i)
        tx_valid_o <= 1'b0;
      case (state_q)
        sbm_pkg::SBM_ST_IDLE:
        begin
          if (can_take && data_mode_o)
          begin
            if (esc_q)
            begin
              esc_q <= 1'b0;
              if (buf_q == `SBM_CODE_CMD)
              begin
                // doubled escape sends the escape value itself
                bus_req_o       <= '{rd: 1'b0, data: buf_q};
                bus_req_valid_o <= 1'b1;
                state_q         <= sbm_pkg::SBM_ST_BUS;
              end
              else
                data_mode_o <= 1'b0;
            end
            else if (buf_q == `SBM_CODE_CMD)
              esc_q <= 1'b1;
            else
            begin
              bus_req_o       <= '{rd: (buf_q == `SBM_CODE_READ), data: buf_q};
              bus_req_valid_o <= 1'b1;
              state_q         <= sbm_pkg::SBM_ST_BUS;
            end
          end
          else if (can_take)
          begin
            if (buf_q == `SBM_CODE_DATA)
              data_mode_o <= 1'b1;
            else if (is_rst)
            begin
              bus_rst_req_o <= 1'b1;
              state_q       <= sbm_pkg::SBM_ST_RST;
            end
            else if (is_pulse)
            begin
              armed_q      <= buf_q[`SBM_PULSE_ARM];
              pulse_vpp_q  <= buf_q[`SBM_PULSE_VPP];
              pulse_code_q <= buf_q & 8'hfe;
              state_q      <= sbm_pkg::SBM_ST_PULSE;
            end
            else if (is_cfg)
            begin
              tx_valid_o <= 1'b1;
              tx_data_o  <= buf_q & 8'hfe;
            end
          end
        end
        sbm_pkg::SBM_ST_BUS:
        begin
          if (bus_done_i)
          begin
            bus_req_valid_o <= 1'b0;
            tx_valid_o      <= 1'b1;
            tx_data_o       <= bus_rd_data_i;
            if (armed_q)
            begin
              // pullup starts with the data reply, no gap
              pulse_vpp_q  <= 1'b0;
              pulse_code_q <= 8'hee;
              state_q      <= sbm_pkg::SBM_ST_PULSE;
            end
            else
              state_q <= sbm_pkg::SBM_ST_IDLE;
          end
        end
        sbm_pkg::SBM_ST_RST:
        begin
          if (bus_rst_done_i)
          begin
            bus_rst_req_o <= 1'b0;
            tx_valid_o    <= 1'b1;
            tx_data_o     <= {`SBM_RST_PREFIX, presence_i};
            state_q       <= sbm_pkg::SBM_ST_IDLE;
          end
        end
        sbm_pkg::SBM_ST_PULSE:
        begin
          if (t_done)
            pulse_end_q <= 1'b1;
          // pulse reply waits until the data reply has left
          if ((t_done || pulse_end_q) && !tx_valid_o)
          begin
            pulse_end_q <= 1'b0;
            tx_valid_o  <= 1'b1;
            tx_data_o   <= pulse_code_q;
            state_q     <= sbm_pkg::SBM_ST_IDLE;
          end
        end
        default:
          state_q <= sbm_pkg::SBM_ST_IDLE;
      endcase
    end
  end

endmodule

// File: tb/sbm_bus_model.sv
// bus side responder for the command sequencer bench
`timescale 1ns/100ps
module sbm_bus_model (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire sbm_pkg::sbm_byte_req_t bus_req_i,
  input  wire logic                   bus_req_valid_i,
  input  wire logic                   bus_rst_req_i,
  output logic                        bus_done_o,
  output logic [7:0]                  bus_rd_data_o,
  output logic                        bus_rst_done_o,
  output logic [1:0]                  presence_o
);
  // =====================================
  // slot timing
  logic [2:0] cnt_q;
  logic [2:0] rcnt_q;
  logic [7:0] val;
  // reads return a fixed pattern, writes echo
  assign val = bus_req_i.rd ? 8'h5a : bus_req_i.data;
  assign bus_done_o = bus_req_valid_i && cnt_q == 3'h3;
  // lines flip outside the sample cycle so stale values never match
  assign bus_rd_data_o = bus_done_o ? val : ~val;
  assign bus_rst_done_o = bus_rst_req_i && rcnt_q == 3'h5;
  assign presence_o = bus_rst_done_o ? 2'h1 : 2'h2;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= 3'h0;
    else if (!bus_req_valid_i || bus_done_o)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_q + 3'h1;
  end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rcnt_q <= 3'h0;
    else if (!bus_rst_req_i || bus_rst_done_o)
      rcnt_q <= 3'h0;
    else
      rcnt_q <= rcnt_q + 3'h1;
  end
endmodule

// File: tb/sbm_cmd_seq_asserts.sv
// port assertions of the command sequencer
`timescale 1ns/100ps
module sbm_cmd_seq_asserts (
  input wire logic                   sys_clk_i,
  input wire logic                   rst_i,
  input wire logic                   rx_valid_i,
  input wire logic [7:0]             rx_data_i,
  input wire logic                   rx_ready_o,
  input wire logic                   tx_valid_o,
  input wire logic [7:0]             tx_data_o,
  input wire sbm_pkg::sbm_byte_req_t bus_req_o,
  input wire logic                   bus_req_valid_o,
  input wire logic                   bus_done_i,
  input wire logic [7:0]             bus_rd_data_i,
  input wire logic                   bus_rst_req_o,
  input wire logic                   bus_rst_done_i,
  input wire logic [1:0]             presence_i,
  input wire logic                   strong_pullup_o,
  input wire logic                   serial_invert_o,
  input wire logic                   data_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_take;
  assign cmd_take = rx_valid_i && rx_ready_o && !data_mode_o;
  // =====================================
  // properties
  property p_cfg_vpp;
    cmd_take && rx_data_i == 8'h29 |-> ##[1:200] tx_valid_o && tx_data_o == 8'h28;
  endproperty
  a_cfg_vpp: assert property (p_cfg_vpp) else $error("vpp reply wrong");
  property p_cfg_spu;
    cmd_take && rx_data_i == 8'h39 |-> ##[1:200] tx_valid_o && tx_data_o == 8'h38;
  endproperty
  a_cfg_spu: assert property (p_cfg_spu) else $error("spu reply wrong");
  property p_inv;
    $rose(serial_invert_o) |-> tx_valid_o && tx_data_o[7:3] == 5'h0f;
  endproperty
  a_inv: assert property (p_inv) else $error("invert without cause");
  property p_mode;
    cmd_take && rx_data_i == 8'he1 && !tx_valid_o |=> !tx_valid_o [*6] ##1 data_mode_o;
  endproperty
  a_mode: assert property (p_mode) else $error("mode entry wrong");
  property p_rst;
    bus_rst_req_o && bus_rst_done_i |=> tx_valid_o && tx_data_o == {6'h33, $past(presence_i)};
  endproperty
  a_rst: assert property (p_rst) else $error("reset reply wrong");
  property p_rd;
    bus_req_valid_o && bus_req_o.data == 8'hff |-> bus_req_o.rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read slots missing");
  property p_echo;
    bus_req_valid_o && bus_done_i |=> tx_valid_o && tx_data_o == $past(bus_rd_data_i);
  endproperty
  a_echo: assert property (p_echo) else $error("bus reply wrong");
  property p_spu_data;
    $rose(strong_pullup_o) && data_mode_o |-> $past(bus_done_i);
  endproperty
  a_spu_data: assert property (p_spu_data) else $error("pullup not after byte");
  property p_pulse_end;
    $fell(strong_pullup_o) |-> ##[0:40] tx_valid_o && tx_data_o[7:5] == 3'h7 && !tx_data_o[0];
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse reply missing");
  property p_buf;
    rx_valid_i && rx_ready_o |=> !rx_ready_o;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer not held");
  c_rst: cover property (bus_rst_req_o && bus_rst_done_i);
  c_read: cover property (bus_req_valid_o && bus_req_o.rd && bus_done_i);
  c_armed: cover property ($fell(strong_pullup_o) && data_mode_o);
endmodule
bind sbm_cmd_seq sbm_cmd_seq_asserts u_chk (.sys_clk_i, .rst_i, .rx_valid_i, .rx_data_i,
  .rx_ready_o, .tx_valid_o, .tx_data_o, .bus_req_o, .bus_req_valid_o, .bus_done_i,
  .bus_rd_data_i, .bus_rst_req_o, .bus_rst_done_i, .presence_i, .strong_pullup_o,
  .serial_invert_o, .data_mode_o);

// File: tb/sbm_cmd_seq_tb.sv
// self-checking bench of the command sequencer
`timescale 1ns/100ps
module sbm_cmd_seq_tb;
  // =====================================
  // clock, reset and wiring
  logic                   sys_clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   rx_valid_i = 1'b0;
  logic [7:0]             rx_data_i = 8'h00;
  logic                   tx_ready_i = 1'b0;
  logic                   rx_ready_o;
  logic                   tx_valid_o;
  logic [7:0]             tx_data_o;
  sbm_pkg::sbm_byte_req_t bus_req_o;
  logic                   bus_req_valid_o;
  logic                   bus_done_i;
  logic [7:0]             bus_rd_data_i;
  logic                   bus_rst_req_o;
  logic                   bus_rst_done_i;
  logic [1:0]             presence_i;
  logic                   strong_pullup_o;
  logic                   prog_pulse_o;
  logic                   serial_invert_o;
  logic [1:0]             baud_sel_o;
  logic                   data_mode_o;
  int                     error_cnt = 0;
  int                     comparisons = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  // short tick so long pulses fit the run
  sbm_cmd_seq #(.TICK_CYCLES(2)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .bus_req_o(bus_req_o), .bus_req_valid_o(bus_req_valid_o), .bus_done_i(bus_done_i),
    .bus_rd_data_i(bus_rd_data_i), .bus_rst_req_o(bus_rst_req_o),
    .bus_rst_done_i(bus_rst_done_i), .presence_i(presence_i),
    .strong_pullup_o(strong_pullup_o), .prog_pulse_o(prog_pulse_o),
    .serial_invert_o(serial_invert_o), .baud_sel_o(baud_sel_o), .data_mode_o(data_mode_o));
  sbm_bus_model u_bus (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_o),
    .bus_req_valid_i(bus_req_valid_o), .bus_rst_req_i(bus_rst_req_o),
    .bus_done_o(bus_done_i), .bus_rd_data_o(bus_rd_data_i),
    .bus_rst_done_o(bus_rst_done_i), .presence_o(presence_i));
  // =====================================
  // host side tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ok(input int n, input int lim);
    if (n >= lim)
    begin
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
    end
  endtask
  // holds the byte until the buffer takes it
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    // one edge between requests so a release is never undone in the same step
    @(posedge sys_clk_i);
    #1 rx_valid_i = 1'b1;
    rx_data_i = b;
    @(negedge sys_clk_i);
    while (rx_ready_o !== 1'b1 && n < 5000)
    begin
      n++;
      @(negedge sys_clk_i);
    end
    wait_ok(n, 5000);
    @(posedge sys_clk_i);
    #1 rx_valid_i = 1'b0;
  endtask
  task automatic recv(input logic [7:0] e, input int lim);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #1 tx_ready_i = 1'b1;
    @(negedge sys_clk_i);
    while (tx_valid_o !== 1'b1 && n < lim)
    begin
      n++;
      @(negedge sys_clk_i);
    end
    wait_ok(n, lim);
    chk(tx_data_o, e);
    @(posedge sys_clk_i);
    #1 tx_ready_i = 1'b0;
  endtask
  task automatic quiet(input logic mode);
    repeat (10) @(posedge sys_clk_i);
    #1 chk({7'h0, tx_valid_o}, 8'h00);
    chk({7'h0, data_mode_o}, {7'h0, mode});
  endtask
  // =====================================
  // tests
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    chk({7'h0, rx_ready_o}, 8'h01);
    chk({7'h0, data_mode_o}, 8'h00);
    $display("test reset done");
    send(8'h29);
    recv(8'h28, 50);
    send(8'h39);
    recv(8'h38, 50);
    for (int v = 0; v < 8; v++)
    begin
      send({4'h7, v[2:0], 1'b1});
      recv({4'h7, v[2:0], 1'b0}, 50);
      chk({7'h0, serial_invert_o}, {7'h0, v[2]});
      chk({6'h0, baud_sel_o}, {6'h0, v[1:0]});
    end
    send(8'h71);
    recv(8'h70, 50);
    $display("test config done");
    send(8'h29);
    send(8'h39);
    chk({7'h0, rx_ready_o}, 8'h00);
    recv(8'h28, 50);
    recv(8'h38, 50);
    send(8'hc1);
    recv(8'hcd, 100);
    $display("test buffer and reset done");
    send(8'he1);
    quiet(1'b1);
    send(8'h44);
    recv(8'h44, 100);
    send(8'hff);
    recv(8'h5a, 100);
    send(8'he3);
    send(8'he3);
    recv(8'he3, 100);
    send(8'he3);
    send(8'h71);
    recv(8'h70, 100);
    quiet(1'b0);
    $display("test data mode done");
    send(8'hfd);
    repeat (900) @(posedge sys_clk_i);
    #1 chk({7'h0, prog_pulse_o}, 8'h01);
    recv(8'hfc, 400);
    send(8'h31);
    recv(8'h30, 50);
    send(8'hef);
    repeat (3) @(posedge sys_clk_i);
    #1 chk({7'h0, strong_pullup_o}, 8'h01);
    send(8'hf1);
    recv(8'hee, 50);
    chk({7'h0, strong_pullup_o}, 8'h00);
    send(8'he1);
    send(8'h44);
    recv(8'h44, 100);
    chk({7'h0, strong_pullup_o}, 8'h01);
    recv(8'hee, 70000);
    send(8'he3);
    send(8'hed);
    send(8'hf1);
    recv(8'hec, 100);
    $display("test pulses done");
    complete_run();
  end
endmodule
